// file: rtl/ccps_strap_config.sv
module ccps_strap_config (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Address and mode strap pin
	input wire logic i_address_mode_pin,
	output logic o_address_mode_pin_oe,
	output logic o_address_mode_pin_val,
	// Role strap pin
	input wire logic i_role_strap_pin,
	output logic o_role_strap_pin_oe,
	output logic o_role_strap_pin_val,
	// Enable, active low
	input wire logic i_enable_n,
	// Slave address match from the serial front end
	input wire logic i_i2c_addr_valid,
	input wire logic [6:0] i_i2c_addr,
	output logic o_i2c_addr_ack,
	// Register-held role and attach state from the detection logic
	input wire logic [1:0] i_reg_role,
	input wire logic i_attached_source,
	// Decoded configuration
	output logic o_cfg_valid,
	output logic o_i2c_mode,
	output logic [6:0] o_i2c_slave_addr,
	output logic [1:0] o_port_role,
	output logic o_core_enable,
	// Source side outputs
	output logic o_bus_power_switch_feed,
	output logic o_source_role_indicator
);

	////////////////////////////////////////////////////////////////////////////////
	// Strap probes
	ccps_strap_if addr_if ();
	ccps_strap_if role_if ();

	assign addr_if.pin_in = i_address_mode_pin;
	assign role_if.pin_in = i_role_strap_pin;
	assign o_address_mode_pin_oe = addr_if.pull_oe;
	assign o_address_mode_pin_val = addr_if.pull_val;
	assign o_role_strap_pin_oe = role_if.pull_oe;
	assign o_role_strap_pin_val = role_if.pull_val;

	ccps_strap_probe #(
		.SETTLE_CYC(ccps_pkg::STRAP_SETTLE_CYC),
		.CNT_W(ccps_pkg::STRAP_CNT_W)
	) u_addr_probe (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.p(addr_if.probe)
	);

	ccps_strap_probe #(
		.SETTLE_CYC(ccps_pkg::STRAP_SETTLE_CYC),
		.CNT_W(ccps_pkg::STRAP_CNT_W)
	) u_role_probe (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.p(role_if.probe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic cfg_done;
		logic i2c_mode;
		logic [6:0] addr;
		ccps_pkg::ccps_role_t strap_role;
		ccps_pkg::ccps_role_t role;
		logic enable;
		logic ack;
		logic power;
		logic src;
	} ccps_cfg_st_t;

	ccps_cfg_st_t s_reg;
	ccps_cfg_st_t s_next;

	ccps_pkg::ccps_role_t eff_role;

	always_comb begin
		s_next = s_reg;
		// Captured once, held until the next reset
		if (!s_reg.cfg_done && addr_if.done && role_if.done) begin
			s_next.cfg_done = 1'b1;
			s_next.i2c_mode = (addr_if.level != ccps_pkg::LVL_FLOAT);
			if (addr_if.level == ccps_pkg::LVL_HIGH) begin
				s_next.addr = ccps_pkg::I2C_ADDR_STRAP_HI;
			end else begin
				s_next.addr = ccps_pkg::I2C_ADDR_STRAP_LO;
			end
			case (role_if.level)
				ccps_pkg::LVL_HIGH: s_next.strap_role = ccps_pkg::ROLE_SRC;
				ccps_pkg::LVL_LOW: s_next.strap_role = ccps_pkg::ROLE_SNK;
				default: s_next.strap_role = ccps_pkg::ROLE_DRP;
			endcase
		end
		// Register mode takes its role from the register; the role lands with the decode
		if (s_next.i2c_mode) begin
			eff_role = ccps_pkg::ccps_role_t'(i_reg_role);
		end else begin
			eff_role = s_next.strap_role;
		end
		s_next.role = eff_role;
		// Low enable required in both modes; register mode relies on the host
		s_next.enable = s_reg.cfg_done && !i_enable_n;
		s_next.ack = s_reg.enable && s_reg.i2c_mode && i_i2c_addr_valid
			&& (i_i2c_addr == s_reg.addr);
		s_next.src = s_reg.enable && i_attached_source && (eff_role != ccps_pkg::ROLE_SNK);
		s_next.power = s_reg.enable && i_attached_source && (eff_role != ccps_pkg::ROLE_SNK);
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			s_reg <= '{cfg_done: 1'b0, i2c_mode: 1'b0, addr: ccps_pkg::I2C_ADDR_STRAP_LO,
				strap_role: ccps_pkg::ROLE_DRP, role: ccps_pkg::ROLE_DRP, enable: 1'b0,
				ack: 1'b0, power: 1'b0, src: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_cfg_valid = s_reg.cfg_done;
	assign o_i2c_mode = s_reg.i2c_mode;
	assign o_i2c_slave_addr = s_reg.addr;
	assign o_port_role = s_reg.role;
	assign o_core_enable = s_reg.enable;
	assign o_i2c_addr_ack = s_reg.ack;
	assign o_bus_power_switch_feed = s_reg.power;
	assign o_source_role_indicator = s_reg.src;

endmodule

// file: rtl/ccps_pkg.sv
package ccps_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Decoded level of a three-level strap
	typedef enum logic [1:0] {
		LVL_LOW = 2'b00,
		LVL_HIGH = 2'b01,
		LVL_FLOAT = 2'b10
	} ccps_lvl_t;

	// Port role
	typedef enum logic [1:0] {
		ROLE_DRP = 2'b00,
		ROLE_SRC = 2'b01,
		ROLE_SNK = 2'b10
	} ccps_role_t;

	////////////////////////////////////////////////////////////////////////////////
	// Slave addresses, seven bits
	localparam logic [6:0] I2C_ADDR_STRAP_LO = 7'h21;
	localparam logic [6:0] I2C_ADDR_STRAP_HI = 7'h31;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned STRAP_SETTLE_NS = 1000;
	localparam int unsigned STRAP_SETTLE_CYC =
		(STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STRAP_CNT_W = 8;

endpackage

// file: rtl/ccps_strap_if.sv
interface ccps_strap_if;
	logic pull_oe;
	logic pull_val;
	logic pin_in;
	logic done;
	ccps_pkg::ccps_lvl_t level;

	modport probe(input pin_in, output pull_oe, output pull_val, output done, output level);
	modport ctrl(input pull_oe, input pull_val, input done, input level, output pin_in);
endinterface

// file: rtl/ccps_strap_probe.sv
// Tells a driven strap from a floating one: pull weakly up, then down,
// and compare what the pin shows after each settle time.
module ccps_strap_probe #(
	parameter int unsigned SETTLE_CYC = ccps_pkg::STRAP_SETTLE_CYC,
	parameter int unsigned CNT_W = ccps_pkg::STRAP_CNT_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Strap pin side
	ccps_strap_if.probe p
);

	generate
		if (SETTLE_CYC < 1 || SETTLE_CYC > (2 ** CNT_W)) begin : g_bad
			$error("ccps_strap_probe: SETTLE_CYC does not fit the counter");
		end
	endgenerate

	localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYC - 1);

	typedef enum logic [1:0] {
		PH_UP = 2'b00,
		PH_DOWN = 2'b01,
		PH_DONE = 2'b10
	} ccps_phase_t;

	typedef struct packed {
		ccps_phase_t phase;
		logic [CNT_W-1:0] cnt;
		logic saw_up;
		ccps_pkg::ccps_lvl_t level;
	} ccps_probe_st_t;

	ccps_probe_st_t s_reg;
	ccps_probe_st_t s_next;

	always_comb begin
		s_next = s_reg;
		case (s_reg.phase)
			PH_UP: begin
				if (s_reg.cnt == LAST) begin
					s_next.saw_up = p.pin_in;
					s_next.cnt = '0;
					s_next.phase = PH_DOWN;
				end else begin
					s_next.cnt = s_reg.cnt + 1'b1;
				end
			end
			PH_DOWN: begin
				if (s_reg.cnt == LAST) begin
					if (s_reg.saw_up && p.pin_in) begin
						s_next.level = ccps_pkg::LVL_HIGH;
					end else if (!s_reg.saw_up && !p.pin_in) begin
						s_next.level = ccps_pkg::LVL_LOW;
					end else begin
						s_next.level = ccps_pkg::LVL_FLOAT;
					end
					s_next.phase = PH_DONE;
				end else begin
					s_next.cnt = s_reg.cnt + 1'b1;
				end
			end
			PH_DONE: begin
				s_next.phase = PH_DONE;
			end
			default: begin
				s_next.phase = PH_DONE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			s_reg <= '{phase: PH_UP, cnt: '0, saw_up: 1'b0, level: ccps_pkg::LVL_FLOAT};
		end else begin
			s_reg <= s_next;
		end
	end

	// Pulls released once decoded to save current
	assign p.pull_oe = (s_reg.phase != PH_DONE);
	assign p.pull_val = (s_reg.phase == PH_UP);
	assign p.done = (s_reg.phase == PH_DONE);
	assign p.level = s_reg.level;

endmodule

// file: sim/ccps_strap_jumper.sv
// Board strap: tied high or low wins over the weak pull; a floating strap
// follows the pull while it is on and wanders every cycle once released.
module ccps_strap_jumper (
	// Clock
	input wire logic i_core_clk,
	// Jumper setting, same coding as the level enum
	input wire logic [1:0] i_lvl,
	// Weak pull from the device
	input wire logic i_oe,
	input wire logic i_val,
	// Pin level seen by the device
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wander_reg = 1'b0;
	always_ff @(posedge i_core_clk) begin
		wander_reg <= ~wander_reg;
	end
	assign o_pin = (i_lvl == 2'h2) ? (i_oe ? i_val : wander_reg) : i_lvl[0];
endmodule

// file: sim/ccps_strap_config_properties.sv
module ccps_strap_config_properties (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Inputs
	input wire logic i_enable_n,
	input wire logic i_i2c_addr_valid,
	input wire logic [6:0] i_i2c_addr,
	input wire logic i_attached_source,
	// Outputs
	input wire logic o_address_mode_pin_oe,
	input wire logic o_i2c_addr_ack,
	input wire logic o_cfg_valid,
	input wire logic o_i2c_mode,
	input wire logic [6:0] o_i2c_slave_addr,
	input wire logic [1:0] o_port_role,
	input wire logic o_core_enable,
	input wire logic o_bus_power_switch_feed,
	input wire logic o_source_role_indicator
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	a_ack_reg_mode: assert property (o_i2c_addr_ack
		|-> o_i2c_mode && $past(i_i2c_addr_valid) && $past(o_core_enable))
		else $error("address ack outside register mode");
	a_ack_own_addr: assert property (o_i2c_addr_ack
		|-> $past(i_i2c_addr) == o_i2c_slave_addr)
		else $error("address ack for foreign address");
	a_enable_follow: assert property (o_cfg_valid && $past(o_cfg_valid)
		|-> o_core_enable == !$past(i_enable_n))
		else $error("core enable does not follow enable input");
	a_cfg_frozen: assert property (o_cfg_valid && $past(o_cfg_valid)
		|-> $stable(o_i2c_mode) && $stable(o_i2c_slave_addr))
		else $error("decoded mode or address changed");
	a_pin_role_frozen: assert property (o_cfg_valid && $past(o_cfg_valid) && !o_i2c_mode
		|-> $stable(o_port_role))
		else $error("pin mode role changed");
	a_src_cause: assert property (o_source_role_indicator |-> $past(i_attached_source)
		&& $past(o_core_enable) && o_port_role != ccps_pkg::ROLE_SNK)
		else $error("source indicator without cause");
	a_feed_match: assert property (o_bus_power_switch_feed == o_source_role_indicator)
		else $error("load switch feed differs from source indicator");
	a_probe_ends: assert property ($fell(o_address_mode_pin_oe) |-> ##[1:2] o_cfg_valid)
		else $error("decode not valid after probe");
endmodule
bind ccps_strap_config ccps_strap_config_properties u_ccps_strap_config_properties (.*);

// file: sim/ccps_strap_config_tb.sv
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module ccps_strap_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 0, i_nrst = 0, i_enable_n = 1, i_i2c_addr_valid = 0, i_attached_source = 0;
	logic [6:0] i_i2c_addr = 7'h00, o_addr;
	logic [1:0] i_reg_role = 2'h0, a_lvl = 2'h2, r_lvl = 2'h2, o_role, ea, er, xr;
	logic a_pin, a_oe, a_val, r_pin, r_oe, r_val, o_ack, o_cfg, o_mode, o_en, o_feed, o_ind;
	int error_cnt = 0, comparisons = 0, cyc = 0, n;
	initial forever #4 i_core_clk = ~i_core_clk;
	ccps_strap_jumper u_ccps_strap_jumper (.i_core_clk, .i_lvl(a_lvl), .i_oe(a_oe), .i_val(a_val),
		.o_pin(a_pin));
	ccps_strap_jumper u_ccps_strap_jumper_role (.i_core_clk, .i_lvl(r_lvl), .i_oe(r_oe),
		.i_val(r_val), .o_pin(r_pin));
	ccps_strap_config u_ccps_strap_config (.i_core_clk, .i_nrst, .i_address_mode_pin(a_pin),
		.o_address_mode_pin_oe(a_oe), .o_address_mode_pin_val(a_val), .i_role_strap_pin(r_pin),
		.o_role_strap_pin_oe(r_oe), .o_role_strap_pin_val(r_val), .i_enable_n, .i_i2c_addr_valid,
		.i_i2c_addr, .o_i2c_addr_ack(o_ack), .i_reg_role, .i_attached_source, .o_cfg_valid(o_cfg),
		.o_i2c_mode(o_mode), .o_i2c_slave_addr(o_addr), .o_port_role(o_role), .o_core_enable(o_en),
		.o_bus_power_switch_feed(o_feed), .o_source_role_indicator(o_ind));
	function automatic logic [6:0] exp_addr(input logic [1:0] a);
		return (a == 2'h1) ? 7'h31 : 7'h21;
	endfunction
	function automatic logic [1:0] exp_role(input logic [1:0] a, input logic [1:0] r,
		input logic [1:0] g);
		if (a != 2'h2) return g;
		if (r == 2'h2) return ccps_pkg::ROLE_DRP;
		return (r == 2'h1) ? ccps_pkg::ROLE_SRC : ccps_pkg::ROLE_SNK;
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic send(input logic [6:0] a, input logic e);
		@(posedge i_core_clk) i_i2c_addr_valid <= 1'b1;
		i_i2c_addr <= a;
		@(posedge i_core_clk) i_i2c_addr_valid <= 1'b0;
		#1 `CHK("ack", e, o_ack)
	endtask
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(6));
		for (int k = 0; k < 9; k++) begin
			ea = 2'(k / 3);
			er = 2'(k % 3);
			@(posedge i_core_clk) i_nrst <= 1'b0;
			a_lvl <= ea;
			r_lvl <= er;
			i_enable_n <= 1'b1;
			i_attached_source <= 1'b0;
			i_reg_role <= 2'($urandom_range(2));
			repeat (2) @(posedge i_core_clk);
			i_nrst <= 1'b1;
			#1 `CHK("pull_up", 4'hF, {a_oe, a_val, r_oe, r_val})
			repeat (ccps_pkg::STRAP_SETTLE_CYC + 4) @(posedge i_core_clk);
			#1 `CHK("pull_down", 4'hA, {a_oe, a_val, r_oe, r_val})
			n = 0;
			while (o_cfg !== 1'b1 && n < 400) begin
				@(posedge i_core_clk);
				n++;
			end
			#1 `CHK("cfg_valid", 1'b1, o_cfg)
			`CHK("pulls_off", 2'h0, {a_oe, r_oe})
			`CHK("mode", ea != 2'h2, o_mode)
			`CHK("addr", exp_addr(ea), o_addr)
			@(posedge i_core_clk) i_enable_n <= 1'b0;
			a_lvl <= 2'($urandom_range(2));
			r_lvl <= 2'($urandom_range(2));
			repeat (3) @(posedge i_core_clk);
			xr = exp_role(ea, er, i_reg_role);
			#1 `CHK("role", xr, o_role)
			`CHK("mode_held", ea != 2'h2, o_mode)
			`CHK("enable", 1'b1, o_en)
			send(exp_addr(ea), ea != 2'h2);
			send(exp_addr(ea) ^ 7'h10, 1'b0);
			@(posedge i_core_clk) i_attached_source <= 1'b1;
			repeat (2) @(posedge i_core_clk);
			#1 `CHK("indicator", xr != ccps_pkg::ROLE_SNK, o_ind)
			`CHK("feed", xr != ccps_pkg::ROLE_SNK, o_feed)
			@(posedge i_core_clk) i_enable_n <= 1'b1;
			repeat (3) @(posedge i_core_clk);
			#1 `CHK("disabled", 1'b0, o_en | o_ind)
			send(exp_addr(ea), 1'b0);
		end
		tally_and_finish();
	end
endmodule
